// ===== rtl/vcd_decoder.v
`timescale 1ns/10ps
`include "vcd_decoder_regs.vh"
module vcd_decoder #(
    parameter UNIT_CYCLES = `VCD_UNIT_CYCLES
)(
    input wire clk,
    input wire rst_b,
    // AXI4-Lite slave
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // Serial command input pins
    input wire ser_clk_pin,
    input wire ser_data_pin,
    // Decoded state
    output wire output_source_option,
    output wire standby_conversion_option,
    output wire amplitude_option,
    output wire cmd_bit3_port_out_hi,
    output wire cmd_bit2_port_out_lo,
    output wire [4:0] ch1_voice_ctrl,
    output wire [4:0] ch2_voice_ctrl,
    output wire ch1_silence,
    output wire ch2_silence,
    output wire tone_active,
    output wire tone_out,
    output wire [7:0] tone_level,
    output wire phrase_strobe,
    output wire [6:0] phrase_addr
);

////////////////////////////////////////////////////////////////////////
// Registers and control state

reg [2:0] ctrl_reg;
reg [7:0] word_reg;
reg [2:0] opt_reg;
reg [1:0] port_reg;
reg [4:0] vctl1_reg;
reg [4:0] vctl2_reg;
reg [3:0] tone_cfg_reg;
reg [1:0] pend_reg;
reg sil_ch1_reg;
reg [6:0] phrase_reg;
reg phrase_stb_reg;

wire chan_sel = ctrl_reg[`VCD_CTRL_CHSEL];
wire serial_mode = ctrl_reg[`VCD_CTRL_SERIAL];
wire mix_8k = ctrl_reg[`VCD_CTRL_MIX8K];

////////////////////////////////////////////////////////////////////////
// Serial input: two-stage synchronisers, then edge detect

reg [1:0] sclk_sync_reg;
reg [1:0] sdat_sync_reg;
reg sclk_last_reg;
reg [7:0] shift_reg;
reg [3:0] bit_cnt_reg;
reg ser_word_v_reg;
reg [7:0] ser_word_reg;

wire sclk_rise = sclk_sync_reg[1] & ~sclk_last_reg;

always @(posedge clk)
begin
    if (!rst_b)
    begin
        sclk_sync_reg <= 2'h0;
        sdat_sync_reg <= 2'h0;
        sclk_last_reg <= 1'b0;
        shift_reg <= 8'h00;
        bit_cnt_reg <= 4'h0;
        ser_word_v_reg <= 1'b0;
        ser_word_reg <= 8'h00;
    end
    else
    begin
        sclk_sync_reg <= {sclk_sync_reg[0], ser_clk_pin};
        sdat_sync_reg <= {sdat_sync_reg[0], ser_data_pin};
        sclk_last_reg <= sclk_sync_reg[1];
        ser_word_v_reg <= 1'b0;
        if (!serial_mode)
            bit_cnt_reg <= 4'h0;
        else if (sclk_rise)
        begin
            // Type bit first, then bit 6 down to bit 0
            shift_reg <= {shift_reg[6:0], sdat_sync_reg[1]};
            if (bit_cnt_reg == 4'h7)
            begin
                bit_cnt_reg <= 4'h0;
                ser_word_v_reg <= 1'b1;
                ser_word_reg <= {shift_reg[6:0], sdat_sync_reg[1]};
            end
            else
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// AXI4-Lite slave

reg bvalid_reg;
reg [1:0] bresp_reg;
reg rvalid_reg;
reg [1:0] rresp_reg;
reg [31:0] rdata_reg;
reg [31:0] rd_mux;
reg rd_hit;

// A serial word owns the decoder this cycle; bus word waits
wire wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg
    & ~ser_word_v_reg;
wire rd_go = s_axi_arvalid & ~rvalid_reg;
wire wr_lane0 = wr_go & s_axi_wstrb[0];
wire wr_ctrl = wr_lane0 & (s_axi_awaddr == `VCD_OFF_CTRL);
wire wr_word = wr_lane0 & (s_axi_awaddr == `VCD_OFF_WORD);
wire wr_known = (s_axi_awaddr == `VCD_OFF_CTRL)
    | (s_axi_awaddr == `VCD_OFF_WORD);

assign s_axi_awready = wr_go;
assign s_axi_wready = wr_go;
assign s_axi_bvalid = bvalid_reg;
assign s_axi_bresp = bresp_reg;
assign s_axi_arready = rd_go;
assign s_axi_rvalid = rvalid_reg;
assign s_axi_rresp = rresp_reg;
assign s_axi_rdata = rdata_reg;

wire sil1_act;
wire sil2_act;

always @*
begin
    rd_hit = 1'b1;
    rd_mux = 32'h00000000;
    case (s_axi_araddr)
        `VCD_OFF_CTRL: rd_mux = {29'h0, ctrl_reg};
        `VCD_OFF_WORD: rd_mux = {24'h0, word_reg};
        `VCD_OFF_STATUS: rd_mux = {22'h0, tone_active, sil2_act,
            sil1_act, pend_reg, port_reg, opt_reg};
        `VCD_OFF_CH1: rd_mux = {27'h0, vctl1_reg};
        `VCD_OFF_CH2: rd_mux = {27'h0, vctl2_reg};
        `VCD_OFF_TONE: rd_mux = {28'h0, tone_cfg_reg};
        `VCD_OFF_PHRASE: rd_mux = {25'h0, phrase_reg};
        default: rd_hit = 1'b0;
    endcase
end

always @(posedge clk)
begin
    if (!rst_b)
    begin
        bvalid_reg <= 1'b0;
        bresp_reg <= `VCD_RESP_OKAY;
        rvalid_reg <= 1'b0;
        rresp_reg <= `VCD_RESP_OKAY;
        rdata_reg <= 32'h00000000;
        ctrl_reg <= `VCD_CTRL_RESET;
        word_reg <= 8'h00;
    end
    else
    begin
        if (wr_go)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_known ? `VCD_RESP_OKAY : `VCD_RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_reg <= 1'b0;
        if (rd_go)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_hit ? `VCD_RESP_OKAY : `VCD_RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_reg <= 1'b0;
        if (wr_ctrl)
            ctrl_reg <= s_axi_wdata[2:0];
        if (wr_word)
            word_reg <= s_axi_wdata[7:0];
        else if (ser_word_v_reg)
            word_reg <= ser_word_reg;
    end
end

////////////////////////////////////////////////////////////////////////
// Command decode

wire word_v = wr_word | ser_word_v_reg;
wire [7:0] word_in = ser_word_v_reg ? ser_word_reg : s_axi_wdata[7:0];
wire is_cmd = word_v & word_in[`VCD_WORD_TYPE];
wire is_addr = word_v & ~word_in[`VCD_WORD_TYPE];
wire [6:0] bits = word_in[6:0];

// Option form 000 a s 0 v; other 00x shapes fall through
wire cmd_opt = is_cmd & (bits[6:4] == 3'h0) & ~bits[1];
wire cmd_sil = is_cmd & (bits[6:5] == 2'h1);
wire cmd_tone = is_cmd & (bits[6:4] == 3'h4);
wire cmd_vctl = is_cmd & (bits[6:5] == 2'h3);

wire sil_start = is_addr & (pend_reg == `VCD_PEND_SIL);
wire tone_start = is_addr & (pend_reg == `VCD_PEND_TONE);

always @(posedge clk)
begin
    if (!rst_b)
    begin
        opt_reg <= `VCD_OPT_RESET;
        port_reg <= 2'h0;
        vctl1_reg <= `VCD_VCTL_RESET;
        vctl2_reg <= `VCD_VCTL_RESET;
        tone_cfg_reg <= `VCD_TONE_RESET;
        pend_reg <= `VCD_PEND_PHRASE;
        sil_ch1_reg <= 1'b1;
        phrase_reg <= 7'h00;
        phrase_stb_reg <= 1'b0;
    end
    else
    begin
        phrase_stb_reg <= 1'b0;
        if (cmd_opt)
        begin
            // Taken even mid-playback; host re-sends the rest
            opt_reg <= {bits[3], bits[2], bits[0]};
            pend_reg <= `VCD_PEND_PHRASE;
        end
        if (cmd_sil)
        begin
            pend_reg <= `VCD_PEND_SIL;
            sil_ch1_reg <= chan_sel;
            if (serial_mode)
                port_reg <= bits[3:2];
        end
        if (cmd_tone)
        begin
            tone_cfg_reg <= bits[3:0];
            pend_reg <= `VCD_PEND_TONE;
        end
        if (cmd_vctl)
        begin
            // Other channel keeps its setting
            if (chan_sel)
                vctl1_reg <= bits[4:0];
            else
                vctl2_reg <= bits[4:0];
        end
        if (is_addr)
        begin
            if (pend_reg == `VCD_PEND_PHRASE)
            begin
                phrase_reg <= bits;
                phrase_stb_reg <= 1'b1;
            end
            pend_reg <= `VCD_PEND_PHRASE;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Duration timers, one unit step is 16.384 ms

wire [31:0] unit_full = UNIT_CYCLES;
wire [18:0] unit_cyc = unit_full[18:0];
wire tone_act;

vcd_dur_timer #(.UNIT_W(19)) u_sil1 (
    .clk(clk),
    .rst_b(rst_b),
    .start(sil_start & sil_ch1_reg),
    .units(bits),
    .unit_cycles(unit_cyc),
    .active(sil1_act),
    .done()
);

vcd_dur_timer #(.UNIT_W(19)) u_sil2 (
    .clk(clk),
    .rst_b(rst_b),
    .start(sil_start & ~sil_ch1_reg),
    .units(bits),
    .unit_cycles(unit_cyc),
    .active(sil2_act),
    .done()
);

vcd_dur_timer #(.UNIT_W(19)) u_tone (
    .clk(clk),
    .rst_b(rst_b),
    .start(tone_start),
    .units(bits),
    .unit_cycles(unit_cyc),
    .active(tone_act),
    .done()
);

////////////////////////////////////////////////////////////////////////
// Tone generator, independent of the phrase path

reg [14:0] half_cyc;
reg [14:0] tdiv_reg;
reg wave_reg;
reg [11:0] r8k_reg;
reg held_reg;
reg [7:0] lvl_raw;
reg [7:0] lvl_reg;

always @*
begin
    case (tone_cfg_reg[1:0])
        2'h0: half_cyc = `VCD_T0_CYC;
        2'h1: half_cyc = `VCD_T1_CYC;
        2'h2: half_cyc = `VCD_T2_CYC;
        2'h3: half_cyc = `VCD_T3_CYC;
        default: half_cyc = `VCD_T0_CYC;
    endcase
    case (tone_cfg_reg[3:2])
        2'h0: lvl_raw = `VCD_LVL0;
        2'h1: lvl_raw = `VCD_LVL1;
        2'h2: lvl_raw = `VCD_LVL2;
        2'h3: lvl_raw = `VCD_LVL3;
        default: lvl_raw = `VCD_LVL0;
    endcase
end

wire tick_8k = (r8k_reg == `VCD_8K_CYC - 12'h001);

always @(posedge clk)
begin
    if (!rst_b)
    begin
        tdiv_reg <= 15'h0000;
        wave_reg <= 1'b0;
        r8k_reg <= 12'h000;
        held_reg <= 1'b0;
        lvl_reg <= 8'h00;
    end
    else
    begin
        r8k_reg <= tick_8k ? 12'h000 : r8k_reg + 12'h001;
        if (!tone_act)
        begin
            tdiv_reg <= 15'h0000;
            wave_reg <= 1'b0;
        end
        else if (tdiv_reg >= half_cyc - 1'b1)
        begin
            tdiv_reg <= 15'h0000;
            wave_reg <= ~wave_reg;
        end
        else
            tdiv_reg <= tdiv_reg + 15'h0001;
        // Sample-and-hold at the phrase rate when mixed
        if (!mix_8k || tick_8k)
            held_reg <= wave_reg & tone_act;
        // Half swing halves the tone too
        lvl_reg <= opt_reg[0] ? {1'b0, lvl_raw[7:1]} : lvl_raw;
    end
end

////////////////////////////////////////////////////////////////////////
// Outputs

assign output_source_option = opt_reg[2];
assign standby_conversion_option = opt_reg[1];
assign amplitude_option = opt_reg[0];
assign cmd_bit3_port_out_hi = port_reg[1];
assign cmd_bit2_port_out_lo = port_reg[0];
assign ch1_voice_ctrl = vctl1_reg;
assign ch2_voice_ctrl = vctl2_reg;
assign ch1_silence = sil1_act;
assign ch2_silence = sil2_act;
assign tone_active = tone_act;
assign tone_out = held_reg;
assign tone_level = lvl_reg;
assign phrase_strobe = phrase_stb_reg;
assign phrase_addr = phrase_reg;
endmodule // vcd_decoder

// ===== rtl/vcd_decoder_regs.vh
`ifndef VCD_DECODER_REGS_VH
`define VCD_DECODER_REGS_VH
// Summary of operation
// - Seven-bit command word, parallel or serial same order
// - Serial first bit: high command, low address
// - Options persist until power loss or reset
// - Option bits: source, standby conversion, amplitude
// - Option code accepted anytime, even during playback
// - Silence code 01x; serial bits 3,2 set ports
// - Channel select level picks silence channel
// - Silence time = address word times 16.384 ms
// - Port outputs low after power-on and reset
// - Tone is channel 1 only, separate generator
// - Tone mixed with 8 kHz phrase uses that rate
// - Tone code 100: bits 3..2 volume, 1..0 frequency
// - Tone volume 1/8, 1/4, 1/3, 1/2 full
// - Tone frequency 0.5, 1.0, 1.3, 2.0 kHz
// - Half-swing option halves tone volume too
// - Tone time = address word times 16.384 ms
// - Voice control 11: fade, repeat, attenuation fields
// - Repeat 1,2,4,infinite; attenuation 0,-6,-12,-18 dB
// - Voice control: select high channel 1, low 2
// - Voice control held until next voice control

// Register byte offsets
`define VCD_OFF_CTRL 8'h00
`define VCD_OFF_WORD 8'h04
`define VCD_OFF_STATUS 8'h08
`define VCD_OFF_CH1 8'h0C
`define VCD_OFF_CH2 8'h10
`define VCD_OFF_TONE 8'h14
`define VCD_OFF_PHRASE 8'h18

// Control register fields and reset value
`define VCD_CTRL_CHSEL 0
`define VCD_CTRL_SERIAL 1
`define VCD_CTRL_MIX8K 2
`define VCD_CTRL_RESET 3'h1

// Word register: type bit above the seven payload bits
`define VCD_WORD_TYPE 7

// Option defaults: filtered, standby enabled, full swing
`define VCD_OPT_RESET 3'h0

// Voice control default: no fade, one repeat, 0 dB
`define VCD_VCTL_RESET 5'h00
`define VCD_TONE_RESET 4'h0

// Pending interpretation of the next address word
`define VCD_PEND_PHRASE 2'h0
`define VCD_PEND_SIL 2'h1
`define VCD_PEND_TONE 2'h2

// Timing
`define VCD_CLK_NS 40
`define VCD_UNIT_NS 16384000
`define VCD_UNIT_CYCLES (`VCD_UNIT_NS / `VCD_CLK_NS)
`define VCD_TONE0_HALF_NS 1000000
`define VCD_TONE1_HALF_NS 500000
`define VCD_TONE2_HALF_NS 384615
`define VCD_TONE3_HALF_NS 250000
`define VCD_PHRASE8K_NS 125000
// Half periods in 40 ns clocks, truncated: 25000, 12500, 9615, 6250
`define VCD_T0_CYC 15'h61A8
`define VCD_T1_CYC 15'h30D4
`define VCD_T2_CYC 15'h258F
`define VCD_T3_CYC 15'h186A
// Phrase sample period at 8 kHz: 3125 clocks
`define VCD_8K_CYC 12'hC35

// Tone levels on an 8-bit full scale: 1/8, 1/4, 1/3, 1/2
`define VCD_LVL0 8'h20
`define VCD_LVL1 8'h40
`define VCD_LVL2 8'h55
`define VCD_LVL3 8'h80

// AXI responses
`define VCD_RESP_OKAY 2'h0
`define VCD_RESP_SLVERR 2'h2
`endif

// ===== rtl/vcd_dur_timer.v
`timescale 1ns/10ps
`include "vcd_decoder_regs.vh"
module vcd_dur_timer #(
    parameter UNIT_W = 19
)(
    input wire clk,
    input wire rst_b,
    input wire start,
    input wire [6:0] units,
    input wire [UNIT_W-1:0] unit_cycles,
    output wire active,
    output wire done
);
reg [UNIT_W-1:0] pre_reg;
reg [6:0] left_reg;
reg active_reg;
reg done_reg;

always @(posedge clk)
begin
    if (!rst_b)
    begin
        pre_reg <= {UNIT_W{1'b0}};
        left_reg <= 7'h00;
        active_reg <= 1'b0;
        done_reg <= 1'b0;
    end
    else
    begin
        done_reg <= 1'b0;
        if (start)
        begin
            // Zero units means no wait at all
            pre_reg <= {UNIT_W{1'b0}};
            left_reg <= units;
            active_reg <= (units != 7'h00);
            done_reg <= (units == 7'h00);
        end
        else if (active_reg)
        begin
            if (pre_reg == unit_cycles - 1'b1)
            begin
                pre_reg <= {UNIT_W{1'b0}};
                left_reg <= left_reg - 7'h01;
                if (left_reg == 7'h01)
                begin
                    active_reg <= 1'b0;
                    done_reg <= 1'b1;
                end
            end
            else
                pre_reg <= pre_reg + 1'b1;
        end
    end
end

assign active = active_reg;
assign done = done_reg;
endmodule // vcd_dur_timer

// ===== test/vcd_checker.sv
`timescale 1ns/10ps
module vcd_checker #(
    parameter UNIT_CYCLES = 409600
)(
    input wire clk,
    input wire rst_b,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire ser_clk_pin,
    input wire output_source_option,
    input wire standby_conversion_option,
    input wire amplitude_option,
    input wire cmd_bit3_port_out_hi,
    input wire cmd_bit2_port_out_lo,
    input wire [4:0] ch1_voice_ctrl,
    input wire [4:0] ch2_voice_ctrl,
    input wire ch1_silence,
    input wire tone_active,
    input wire [7:0] tone_level,
    input wire phrase_strobe
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_b);
wire take_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
wire [2:0] opts = {output_source_option, standby_conversion_option,
    amplitude_option};
reg ser_q;
reg [3:0] quiet;
reg [31:0] sil_len;
reg [31:0] tone_len;
////////////////////////////////////////////////////////////////////////////
// Cycles since the last word could have arrived, bus or serial
always @(posedge clk)
begin
    ser_q <= ser_clk_pin;
    if (!rst_b || take_w || (ser_clk_pin && !ser_q))
        quiet <= 4'h0;
    else if (quiet != 4'hF)
        quiet <= quiet + 4'h1;
    sil_len <= ch1_silence ? sil_len + 1 : 0;
    tone_len <= tone_active ? tone_len + 1 : 0;
end
sequence s_wtake;
    take_w;
endsequence
sequence s_rtake;
    s_axi_arvalid && s_axi_arready;
endsequence
////////////////////////////////////////////////////////////////////////////
a_port_reset: assert property ($rose(rst_b) |->
    !cmd_bit3_port_out_hi && !cmd_bit2_port_out_lo)
    else $error("port outputs not low after reset");
a_opt_reset: assert property ($rose(rst_b) |-> opts == 3'h0)
    else $error("options not default after reset");
a_settings_cause: assert property ($changed({opts, ch1_voice_ctrl,
    ch2_voice_ctrl}) |-> quiet < 4'hC)
    else $error("settings changed with no word received");
a_write_answer: assert property (s_wtake |=> s_axi_bvalid)
    else $error("write response missing");
a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
a_read_answer: assert property (s_rtake |=> s_axi_rvalid)
    else $error("read answer missing");
a_strobe_pulse: assert property (phrase_strobe |=> !phrase_strobe)
    else $error("phrase strobe longer than one cycle");
a_tone_full: assert property (tone_active && !$past(amplitude_option)
    |-> tone_level inside {8'h20, 8'h40, 8'h55, 8'h80})
    else $error("tone level not a full swing step");
a_tone_half: assert property (tone_active && $past(amplitude_option)
    |-> tone_level inside {8'h10, 8'h20, 8'h2A, 8'h40})
    else $error("tone level not a half swing step");
a_sil_units: assert property ($fell(ch1_silence) |->
    sil_len % UNIT_CYCLES == 0 && sil_len <= 127 * UNIT_CYCLES)
    else $error("silence length not whole units");
a_tone_units: assert property ($fell(tone_active) |->
    tone_len % UNIT_CYCLES == 0 && tone_len <= 127 * UNIT_CYCLES)
    else $error("tone length not whole units");
endmodule // vcd_checker
bind vcd_decoder vcd_checker #(.UNIT_CYCLES(UNIT_CYCLES)) CHK (
    .clk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .ser_clk_pin,
    .output_source_option, .standby_conversion_option, .amplitude_option,
    .cmd_bit3_port_out_hi, .cmd_bit2_port_out_lo, .ch1_voice_ctrl,
    .ch2_voice_ctrl, .ch1_silence, .tone_active, .tone_level,
    .phrase_strobe);

// ===== test/vcd_host_model.sv
`timescale 1ns/10ps
module vcd_host_model (
    input wire clk,
    output reg ser_clk_pin,
    output reg ser_data_pin
);
initial
begin
    ser_clk_pin = 1'b0;
    ser_data_pin = 1'b0;
end
// Type bit first, then payload bits high to low; clock idles low
task send(input [7:0] w);
    integer b;
    begin
        for (b = 7; b >= 0; b = b - 1)
        begin
            @(posedge clk);
            ser_data_pin <= w[b];
            repeat (4) @(posedge clk);
            ser_clk_pin <= 1'b1;
            repeat (4) @(posedge clk);
            ser_clk_pin <= 1'b0;
        end
        @(posedge clk);
        ser_data_pin <= ~w[0];
    end
endtask
endmodule // vcd_host_model

// ===== test/vcd_decoder_tb.sv
`timescale 1ns/10ps
`include "vcd_decoder_regs.vh"
module vcd_decoder_tb;
reg clk = 1'b0;
reg rst_b = 1'b0;
reg [7:0] s_axi_awaddr = 8'h00;
reg [7:0] s_axi_araddr = 8'h00;
reg [31:0] s_axi_wdata = 32'h0;
reg [3:0] s_axi_wstrb = 4'hF;
reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
wire s_axi_rvalid, ser_clk_pin, ser_data_pin, tone_out, phrase_strobe;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
wire output_source_option, standby_conversion_option, amplitude_option;
wire cmd_bit3_port_out_hi, cmd_bit2_port_out_lo, ch1_silence, ch2_silence;
wire tone_active;
wire [4:0] ch1_voice_ctrl, ch2_voice_ctrl;
wire [7:0] tone_level;
wire [6:0] phrase_addr;
integer n_mismatch = 0, n_checks = 0, i, strobes = 0;
reg [1:0] sel = 2'h0;
reg [31:0] cnt = 0, last = 0, rise = 0;
reg tone_q = 1'b0;
reg [7:0] lv;
wire mon = sel == 2'h0 ? ch1_silence : sel == 2'h1 ? ch2_silence
    : tone_active;
wire [2:0] opts = {output_source_option, standby_conversion_option,
    amplitude_option};
vcd_decoder #(.UNIT_CYCLES(64)) DUT (
    .clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ser_clk_pin, .ser_data_pin, .output_source_option,
    .standby_conversion_option, .amplitude_option, .cmd_bit3_port_out_hi,
    .cmd_bit2_port_out_lo, .ch1_voice_ctrl, .ch2_voice_ctrl, .ch1_silence,
    .ch2_silence, .tone_active, .tone_out, .tone_level, .phrase_strobe,
    .phrase_addr);
vcd_host_model HOST (.clk, .ser_clk_pin, .ser_data_pin);
always #20 clk = ~clk;
// Length of the last high stretch of the watched timer output
always @(posedge clk)
begin
    cnt <= mon ? cnt + 1 : 0;
    if (!mon && cnt != 0)
        last <= cnt;
    if (phrase_strobe)
        strobes <= strobes + 1;
    // Tone clocks elapsed at the latest tone rising edge
    tone_q <= tone_out;
    if (tone_out && !tone_q)
        rise <= cnt;
end
////////////////////////////////////////////////////////////////////////////
task end_of_test;
    begin
        if (n_mismatch == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
endtask
task chk(input [31:0] got, input [31:0] exp);
    begin
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
endtask
task hang(input integer k);
    begin
        if (k > 200)
        begin
            n_mismatch = n_mismatch + 1;
            end_of_test;
        end
    end
endtask
task wr(input [7:0] a, input [31:0] d, input [1:0] r);
    integer k;
    begin
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        k = 0;
        @(negedge clk);
        while (!(s_axi_awready && s_axi_wready))
        begin
            @(negedge clk);
            k = k + 1;
            hang(k);
        end
        @(posedge clk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        @(negedge clk);
        while (!s_axi_bvalid)
        begin
            @(negedge clk);
            k = k + 1;
            hang(k);
        end
        chk(s_axi_bresp, r);
        // Bready stays high, so back-to-back writes never toggle it
        @(posedge clk);
    end
endtask
task rd(input [7:0] a, input [31:0] e, input [1:0] r);
    integer k;
    begin
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        k = 0;
        @(negedge clk);
        while (!s_axi_arready)
        begin
            @(negedge clk);
            k = k + 1;
            hang(k);
        end
        @(posedge clk);
        s_axi_arvalid <= 1'b0;
        @(negedge clk);
        while (!s_axi_rvalid)
        begin
            @(negedge clk);
            k = k + 1;
            hang(k);
        end
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, r);
        @(posedge clk);
        s_axi_rready <= 1'b0;
    end
endtask
task word(input [7:0] w);
    wr(`VCD_OFF_WORD, {24'h0, w}, `VCD_RESP_OKAY);
endtask
// Wait out the watched timer, then compare its length
task dur(input [31:0] e);
    integer k;
    begin
        for (k = 0; k < 10000 && mon; k = k + 1)
            @(posedge clk);
        if (mon)
            hang(k);
        repeat (2) @(posedge clk);
        chk(last, e);
    end
endtask
task reset2;
    begin
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
    end
endtask
////////////////////////////////////////////////////////////////////////////
initial
begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(`VCD_OFF_STATUS, 32'h0, `VCD_RESP_OKAY);
    for (i = 0; i < 4; i = i + 1)
    begin
        lv = i == 0 ? 8'h08 : i == 1 ? 8'h04 : i == 2 ? 8'h01 : 8'h0D;
        word(8'h80 | lv);
        chk(opts, {lv[3], lv[2], lv[0]});
    end
    for (i = 0; i < 3; i = i + 1)
    begin
        word(i == 0 ? 8'h82 : i == 1 ? 8'h90 : 8'hD0);
        chk(opts, 3'h7);
    end
    reset2;
    chk(opts, 3'h0);
    wr(`VCD_OFF_CTRL, 32'h1, `VCD_RESP_OKAY);
    word(8'hF5);
    wr(`VCD_OFF_CTRL, 32'h0, `VCD_RESP_OKAY);
    for (i = 0; i < 32; i = i + 1)
    begin
        word(8'hE0 | i[4:0]);
        chk(ch2_voice_ctrl, i[4:0]);
    end
    chk(ch1_voice_ctrl, 5'h15);
    sel = 2'h2;
    for (i = 0; i < 8; i = i + 1)
    begin
        if (i == 4)
            word(8'h81);
        lv = i[1:0] == 0 ? `VCD_LVL0 : i[1:0] == 1 ? `VCD_LVL1
            : i[1:0] == 2 ? `VCD_LVL2 : `VCD_LVL3;
        word(8'hC0 | {i[1:0], ~i[1:0]});
        word(i + 1);
        chk(tone_level, lv >> i[2]);
        dur((i + 1) * 64);
    end
    word(8'hC3);
    word(8'h7F);
    dur(127 * 64);
    chk(rise, `VCD_T3_CYC + 1);
    for (i = 0; i < 2; i = i + 1)
    begin
        sel = {1'b0, ~i[0]};
        wr(`VCD_OFF_CTRL, i, `VCD_RESP_OKAY);
        word(8'hA0);
        word(3 + 2 * i);
        dur(192 + 128 * i);
    end
    word(8'hA0);
    word(8'h00);
    chk(strobes, 0);
    word(8'h15);
    @(posedge clk);
    chk(strobes, 1);
    chk(phrase_addr, 7'h15);
    wr(`VCD_OFF_CTRL, 32'h3, `VCD_RESP_OKAY);
    HOST.send(8'hA8);
    repeat (10) @(posedge clk);
    chk({cmd_bit3_port_out_hi, cmd_bit2_port_out_lo}, 2'h2);
    HOST.send(8'h01);
    HOST.send(8'h84);
    repeat (10) @(posedge clk);
    chk(opts, 3'h2);
    HOST.send(8'hC0);
    HOST.send(8'hA4);
    repeat (10) @(posedge clk);
    chk({cmd_bit3_port_out_hi, cmd_bit2_port_out_lo}, 2'h1);
    reset2;
    chk({cmd_bit3_port_out_hi, cmd_bit2_port_out_lo}, 2'h0);
    wr(8'h1C, 32'h0, `VCD_RESP_SLVERR);
    wr(`VCD_OFF_STATUS, 32'h0, `VCD_RESP_SLVERR);
    rd(8'h1C, 32'h0, `VCD_RESP_SLVERR);
    s_axi_wstrb <= 4'hE;
    wr(`VCD_OFF_CTRL, 32'h6, `VCD_RESP_OKAY);
    rd(`VCD_OFF_CTRL, 32'h1, `VCD_RESP_OKAY);
    end_of_test;
end
initial
begin
    #4000000;
    n_mismatch = n_mismatch + 1;
    end_of_test;
end
endmodule // vcd_decoder_tb
